// file: testbench/shp_host_model.sv
// Host processor model that drives the register port pins.
// Assumes one caller at a time and a free running host bus clock.
`timescale 1ns/100ps
module shp_host_model
    import shp_pkg::*;
(
    input wire logic clk,
    output shp_host_req_s hostReq
);
    initial begin
        hostReq = '0;
        hostReq.chipSelectN = 1'b1;
    end

    // Address phase n times (reloading a+i), then one execute phase
    task automatic acc(input logic wnr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input int n, input logic csA, input logic csE);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) #1;
            hostReq.chipSelectN = csA;
            hostReq.addressStrobeN = 1'b0;
            hostReq.writeNotRead = wnr;
            hostReq.addr = a + 7'(i);
            hostReq.wrData = ~d;
        end
        @(posedge clk) #1;
        hostReq.chipSelectN = csE;
        hostReq.addressStrobeN = 1'b1;
        hostReq.wrData = d;
        @(posedge clk) #1;
        // Deselected pins show changing junk, never the last value
        hostReq.chipSelectN = 1'b1;
        hostReq.addressStrobeN = ~hostReq.addressStrobeN;
        hostReq.writeNotRead = ~hostReq.writeNotRead;
        hostReq.addr = ~hostReq.addr;
        hostReq.wrData = ~hostReq.wrData;
    endtask : acc
endmodule : shp_host_model

// file: testbench/testbench.sv
// Self-checking bench for the host register port with a host model.
// Assumes the port's own assertions run alongside.
`timescale 1ns/100ps
module testbench import shp_pkg::*; ;
    logic clk;
    logic rst;
    shp_host_req_s hostReq;
    logic busWidthSelect;
    logic outputEnableN;
    logic [DATA_W-1:0] dataOut;
    logic [LANES-1:0] dataDriveN;
    logic [ADDR_W-1:0] coreRdAddr;
    logic [DATA_W-1:0] coreRdData;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [LANES+DATA_W-1:0] expQ [$];
    int errors = 0;
    int numChecks = 0;
    int seed = 13775;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    shp_host_port dut (.clk(clk), .rst(rst), .hostReq(hostReq),
        .busWidthSelect(busWidthSelect), .outputEnableN(outputEnableN), .dataOut(dataOut),
        .dataDriveN(dataDriveN), .coreRdAddr(coreRdAddr), .coreRdData(coreRdData));
    shp_host_model host (.clk(clk), .hostReq(hostReq));

    task automatic print_verdict();
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic do_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int n,
            input logic csA, input logic csE);
        logic [ADDR_W-1:0] t;
        t = a + 7'(n - 1);
        host.acc(1'b1, a, d, n, csA, csE);
        if (!csA && !csE) begin
            mem[t][7:0] = d[7:0];
            if (!busWidthSelect) mem[t][15:8] = d[15:8];
        end
    endtask : do_wr

    task automatic do_rd(input logic [ADDR_W-1:0] a, input logic oe);
        outputEnableN = oe;
        if (!oe) expQ.push_back(busWidthSelect ? {2'b10, 8'h00, mem[a][7:0]} : {2'b00, mem[a]});
        host.acc(1'b0, a, 16'h0000, 1, 1'b0, 1'b0);
    endtask : do_rd

    // Lanes are driven only mid execute period; each drive consumes one note
    always @(negedge clk) begin
        if (!rst && dataDriveN !== 2'b11) begin
            numChecks++;
            if (expQ.size() == 0) begin
                $display("mismatch at %0t: unexpected drive", $time);
                errors++;
            end else if ({dataDriveN, dataOut} !== expQ.pop_front()) begin
                $display("mismatch at %0t: read data or lanes", $time);
                errors++;
            end
        end
    end

    initial begin
        rst = 1'b1;
        busWidthSelect = 1'b0;
        outputEnableN = 1'b1;
        coreRdAddr = 7'h00;
        foreach (mem[i]) mem[i] = 16'h0000;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        for (int k = 0; k < 80; k++) begin
            busWidthSelect = 1'($random(seed));
            do_wr(7'($random(seed) & 7), 16'($random(seed)), 1 + ($random(seed) & 3),
                ($random(seed) & 7) == 0, ($random(seed) & 7) == 0);
            do_rd(7'($random(seed) & 15), ($random(seed) & 3) == 0);
        end
        for (int k = 0; k < 16; k++) begin
            coreRdAddr = 7'(k);
            repeat (2) @(posedge clk);
            #1 numChecks++;
            if (coreRdData !== mem[k]) begin
                $display("mismatch at %0t: stored value", $time);
                errors++;
            end
        end
        numChecks++;
        if (expQ.size() != 0) begin
            $display("mismatch at %0t: missing read drive", $time);
            errors++;
        end
        print_verdict();
    end

    initial begin
        #50000;
        $display("mismatch at %0t: timeout", $time);
        errors++;
        print_verdict();
    end
endmodule : testbench

// file: verilog/shp_host_port.sv
// Synchronous host register port: address phase then execute phase.
// Assumes the host keeps the bus clock running and drives pins synchronously.
//
// What this block does
// - Width select picks 8-bit or 16-bit data
// - Sample all inputs on clock except OE and the asynchronous reset
// - Every access is address then execute
// - Address load and write happen only while chip select low; read lanes drive the next period even if select is high
// - Strobe low captures address for next period
// - Strobe high, select low executes pending access
// - Strobe held low reloads and writes nothing; lanes of a read just addressed still drive in the held period
// - Direction low at address means read
// - Direction high stores data ending execute
// - Drive data only on read with OE
// - Seven-bit address loaded while strobe low
`timescale 1ns/100ps
module shp_host_port
    import shp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire shp_host_req_s hostReq,
    input wire logic busWidthSelect,
    input wire logic outputEnableN,
    output logic [DATA_W-1:0] dataOut,
    output logic [LANES-1:0] dataDriveN,
    input wire logic [ADDR_W-1:0] coreRdAddr,
    output logic [DATA_W-1:0] coreRdData
);
    shp_phase_e phase_q;
    shp_phase_e phase_d;
    logic [ADDR_W-1:0] addr_q;
    logic isWrite_q;
    logic [LANES-1:0] laneArmed_q;
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] coreRdData_q;
    logic [DATA_W-1:0] hostRdData;
    logic [DATA_W-1:0] coreRdRaw;
    logic selected;
    logic addrPhase;
    logic execPhase;
    logic [LANES-1:0] laneMask;
    shp_wr_s wr;

    // Pin terms are plain samples of synchronous inputs
    assign selected = !hostReq.chipSelectN;
    assign addrPhase = selected && !hostReq.addressStrobeN;
    assign execPhase = selected && hostReq.addressStrobeN && (phase_q == ST_ADDRESSED);
    assign laneMask = busWidthSelect ? LANES_LOW : LANES_ALL;

    always_comb begin
        phase_d = ST_IDLE;
        unique case (phase_q)
            ST_IDLE: begin
                if (addrPhase) begin
                    phase_d = ST_ADDRESSED;
                end
            end
            ST_ADDRESSED: begin
                // One execute period returns to idle; a held strobe keeps addressing
                if (addrPhase) begin
                    phase_d = ST_ADDRESSED;
                end else begin
                    phase_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= ST_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Address and direction captured together while strobe is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= ADDR_RST;
            isWrite_q <= 1'b0;
        end else if (addrPhase) begin
            addr_q <= hostReq.addr;
            isWrite_q <= hostReq.writeNotRead;
        end
    end

    // Write data is taken at the edge that closes the execute period
    always_comb begin
        wr.en = execPhase && isWrite_q;
        wr.byteEn = laneMask;
        wr.addr = addr_q;
        wr.data = hostReq.wrData;
    end

    // Read data is fetched at the address edge so it is valid all through
    // the execute period; a lookahead costs nothing since the array is flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_q <= DATA_RST;
            laneArmed_q <= LANES_OFF;
        end else if (addrPhase) begin
            rdData_q <= hostRdData & {{8{!busWidthSelect}}, 8'hFF};
            laneArmed_q <= hostReq.writeNotRead ? LANES_OFF : laneMask;
        end else begin
            laneArmed_q <= LANES_OFF;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coreRdData_q <= DATA_RST;
        end else begin
            coreRdData_q <= coreRdRaw;
        end
    end

    shp_reg_array #(
        .AW(ADDR_W),
        .DW(DATA_W)
    ) u_regs (
        .clk(clk),
        .rst(rst),
        .wr(wr),
        .hostRdAddr(hostReq.addr),
        .hostRdData(hostRdData),
        .coreRdAddr(coreRdAddr),
        .coreRdData(coreRdRaw)
    );

    assign dataOut = rdData_q;
    assign coreRdData = coreRdData_q;
    // Output enable acts without the clock, so only this gate follows it
    assign dataDriveN = ~laneArmed_q | {LANES{outputEnableN}};

    sequence seqAddrWrite;
        !hostReq.chipSelectN && !hostReq.addressStrobeN && hostReq.writeNotRead;
    endsequence

    sequence seqAddrRead;
        !hostReq.chipSelectN && !hostReq.addressStrobeN && !hostReq.writeNotRead;
    endsequence

    sequence seqExec;
        !hostReq.chipSelectN && hostReq.addressStrobeN;
    endsequence

    sequence seqAddrAny;
        !hostReq.chipSelectN && !hostReq.addressStrobeN;
    endsequence

    AST_ADDR_CAPTURE: assert property (@(posedge clk) disable iff (rst)
        addrPhase |=> (addr_q == $past(hostReq.addr)) && (phase_q == ST_ADDRESSED))
        else $error("Address not captured on strobe");

    AST_WRITE_EXEC: assert property (@(posedge clk) disable iff (rst)
        seqAddrWrite ##1 seqExec |-> wr.en && (wr.addr == $past(hostReq.addr)))
        else $error("Write not executed at captured address");

    AST_READ_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
        seqAddrRead ##1 seqExec |-> !wr.en && (laneArmed_q == $past(laneMask)))
        else $error("Read phase misbehaved");

    AST_STROBE_NO_OP: assert property (@(posedge clk) disable iff (rst)
        !hostReq.addressStrobeN |-> !wr.en)
        else $error("Operation executed while strobe low");

    AST_DESELECT_IDLE: assert property (@(posedge clk) disable iff (rst)
        hostReq.chipSelectN |-> !wr.en ##1 (phase_q == ST_IDLE) && (laneArmed_q == LANES_OFF))
        else $error("Activity while deselected");

    AST_TWO_CYCLES: assert property (@(posedge clk) disable iff (rst)
        seqAddrWrite ##1 seqExec |=> (phase_q == ST_IDLE) && !wr.en)
        else $error("Access did not end after two cycles");

    AST_DRIVE_READ_ONLY: assert property (@(posedge clk) disable iff (rst)
        (dataDriveN != LANES_ALL) |-> !outputEnableN && $past(addrPhase)
            && !$past(hostReq.writeNotRead))
        else $error("Data bus driven outside a read");

    AST_BYTE_MODE: assert property (@(posedge clk) disable iff (rst)
        busWidthSelect |-> (wr.byteEn == LANES_LOW) && dataDriveN[1])
        else $error("Upper lane used in 8-bit mode");

    AST_READ_DATA: assert property (@(posedge clk) disable iff (rst)
        seqAddrRead ##1 seqExec ##0 (busWidthSelect == $past(busWidthSelect))
            |-> dataOut[7:0] == $past(hostRdData[7:0]))
        else $error("Read data not from captured address");

    // Refusals: a dropped select, a lone strobe-high period and a held
    // strobe must never reach the array, since software cannot undo a
    // stray write into a control register
    AST_EXEC_DROPPED: assert property (@(posedge clk) disable iff (rst)
        seqAddrWrite ##1 hostReq.chipSelectN |-> !wr.en)
        else $error("Write executed with chip select high");

    AST_NO_EXEC_UNADDRESSED: assert property (@(posedge clk) disable iff (rst)
        seqExec ##0 (phase_q == ST_IDLE) |-> !wr.en && (laneArmed_q == LANES_OFF))
        else $error("Execute without a captured address");

    AST_HELD_RELOAD: assert property (@(posedge clk) disable iff (rst)
        seqAddrAny ##1 seqAddrAny |-> !wr.en && (phase_q == ST_ADDRESSED)
            && (addr_q == $past(hostReq.addr)))
        else $error("Held strobe did not reload the address");

    AST_WIDE_LANES: assert property (@(posedge clk) disable iff (rst)
        !busWidthSelect |-> (wr.byteEn == LANES_ALL))
        else $error("Upper lane not written in 16-bit mode");

    AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
        $past(addrPhase) && $past(busWidthSelect) |-> (dataOut[15:8] == 8'h00))
        else $error("Upper read lane not zero in 8-bit mode");

    AST_DRIVE_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
        (laneArmed_q != LANES_OFF) |-> $past(addrPhase) && !$past(hostReq.writeNotRead))
        else $error("Read lanes armed outside the execute period");

    AST_WRITE_DATA: assert property (@(posedge clk) disable iff (rst)
        seqAddrWrite ##1 seqExec |-> (wr.data == hostReq.wrData))
        else $error("Write data not taken at execute edge");
endmodule : shp_host_port

// file: verilog/shp_pkg.sv
// Shared constants, states and carriers for the synchronous host register port.
// Assumes a single host bus clock drives every flip-flop of the port.
package shp_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int LANES = DATA_W / 8;
    localparam int DEPTH = 1 << ADDR_W;

    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [LANES-1:0] LANES_ALL = 2'h3;
    localparam logic [LANES-1:0] LANES_LOW = 2'h1;
    localparam logic [LANES-1:0] LANES_OFF = 2'h0;

    // Phase tracker: idle, or an address is held for the next execute phase
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_ADDRESSED = 1'b1
    } shp_phase_e;

    // Host pins sampled on the host bus clock; all strobes active low
    typedef struct packed {
        logic chipSelectN;
        logic addressStrobeN;
        logic writeNotRead;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } shp_host_req_s;

    // One write into the register array
    typedef struct packed {
        logic en;
        logic [LANES-1:0] byteEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } shp_wr_s;
endpackage : shp_pkg

// file: verilog/shp_reg_array.sv
// Register storage behind the host port: one write port, two read ports.
// Assumes writes arrive as single-cycle strobes from the host port logic.
`timescale 1ns/100ps
module shp_reg_array
    import shp_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire shp_wr_s wr,
    input wire logic [AW-1:0] hostRdAddr,
    output logic [DW-1:0] hostRdData,
    input wire logic [AW-1:0] coreRdAddr,
    output logic [DW-1:0] coreRdData
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Reset clears the array so reads are defined before any write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < (1 << AW); i++) begin
                mem[i] <= DATA_RST;
            end
        end else if (wr.en) begin
            for (int b = 0; b < DW / 8; b++) begin
                if (wr.byteEn[b]) begin
                    mem[wr.addr][b*8 +: 8] <= wr.data[b*8 +: 8];
                end
            end
        end
    end

    assign hostRdData = mem[hostRdAddr];
    assign coreRdData = mem[coreRdAddr];
endmodule : shp_reg_array
